/* inc/pf_pkg.sv */
package pf_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STAMP_RES_MS = 1;
  localparam int unsigned EVAL_PERIOD_MS = 5;
  localparam int unsigned CYCLES_PER_MS_DEF = CLK_HZ / 1000 * STAMP_RES_MS;
  localparam int unsigned DIV_W = 17;
  localparam logic [2:0] MS_PER_EVAL = 3'(EVAL_PERIOD_MS / STAMP_RES_MS);

  // Sample history for fault records
  localparam int unsigned PRE_TRIGGER_MS = 20;
  localparam int unsigned PRE_FAULT_MS = 200;
  localparam int unsigned PRE_TRIGGER_IDX = PRE_TRIGGER_MS / EVAL_PERIOD_MS;
  localparam int unsigned PRE_FAULT_IDX = PRE_FAULT_MS / EVAL_PERIOD_MS;
  localparam int unsigned HIST_DEPTH = PRE_FAULT_IDX + 1;

  // Widths and limits
  localparam int unsigned THR_W = 7;
  localparam int unsigned TIME_W = 19;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned REC_DEPTH = 12;
  localparam logic [15:0] RELEASE_PCT = 16'h0067;
  localparam logic [15:0] PF_SCALE = 16'h0064;

  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRIP_DELAY = 8'h04;
  localparam logic [7:0] OFS_ALARM_DELAY = 8'h08;
  localparam logic [7:0] OFS_RELEASE_DELAY = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_TRIP_REMAIN = 8'h14;
  localparam logic [7:0] OFS_ALARM_REMAIN = 8'h18;
  localparam logic [7:0] OFS_RATIO = 8'h1C;
  localparam logic [7:0] OFS_CNT_A = 8'h20;
  localparam logic [7:0] OFS_CNT_B = 8'h24;
  localparam logic [7:0] OFS_CNT_C = 8'h28;
  localparam logic [7:0] OFS_REC_SEL = 8'h2C;
  localparam logic [7:0] OFS_REC_STAMP = 8'h30;
  localparam logic [7:0] OFS_REC_DATA = 8'h34;
  localparam logic [7:0] OFS_REC_TIME = 8'h38;
  localparam logic [2:0] OFS_THR_PAGE = 3'h2;

  // Control register fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_ALARMS_BIT = 3;
  localparam int unsigned CTRL_FORCE_LSB = 4;
  localparam int unsigned CTRL_FORCE_EN_BIT = 7;
  localparam int unsigned CTRL_STORE_ON_BIT = 8;
  localparam int unsigned CTRL_STORE_OFF_BIT = 9;
  localparam int unsigned CTRL_CLEAR_BIT = 10;

  // Reset values
  localparam logic [THR_W-1:0] TRIP_THR_RST = 7'h50;
  localparam logic [THR_W-1:0] ALARM_THR_RST = 7'h5A;
  localparam logic [TIME_W-1:0] TRIP_DELAY_RST = 19'h00014;
  localparam logic [TIME_W-1:0] ALARM_DELAY_RST = 19'h00014;
  localparam logic [TIME_W-1:0] RELEASE_DELAY_RST = 19'h00000;

  typedef enum logic [2:0] {
    MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF
  } node_operating_mode_t;

  typedef enum logic [2:0] {
    ST_NORMAL, ST_START, ST_TRIP, ST_BLOCKED, ST_ALARM_START, ST_ALARM
  } status_t;

  // Event sources; event code is 2*source, plus one for the OFF event
  localparam int unsigned SRC_BLOCK = 0;
  localparam int unsigned SRC_START = 1;
  localparam int unsigned SRC_TRIP = 2;
  localparam int unsigned SRC_ALARM_START = 3;
  localparam int unsigned SRC_ALARM = 4;
  localparam int unsigned NUM_SRC = 5;

endpackage

/* hw/definite_time_timer.sv */
`timescale 1ns/1ps
module definite_time_timer import pf_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic tick,
  input wire logic run,
  input wire logic [TIME_W-1:0] op_delay,
  input wire logic [TIME_W-1:0] rel_delay,
  // Status
  output logic expired,
  output logic [TIME_W-1:0] remaining
);

  logic [TIME_W-1:0] count_q, count_d;
  logic [TIME_W-1:0] rel_q, rel_d;

  // Definite time only: a fixed count of evaluation ticks
  always_comb begin
    count_d = count_q;
    rel_d = rel_q;
    if (run) begin
      rel_d = '0;
      if (count_q < op_delay) begin
        count_d = count_q + 1'b1;
      end
    end else if (count_q != '0) begin
      // Release delay: the elapsed count survives short dropouts
      if (TIME_W'(rel_q + 1'b1) >= rel_delay) begin
        count_d = '0;
        rel_d = '0;
      end else begin
        rel_d = rel_q + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
      rel_q <= '0;
      expired <= 1'b0;
      remaining <= '0;
    end else if (tick) begin
      count_q <= count_d;
      rel_q <= rel_d;
      expired <= run && (count_d >= op_delay);
      remaining <= (run && count_d < op_delay) ? TIME_W'(op_delay - count_d) : '0;
    end
  end

endmodule

/* hw/power_factor_under_stage.sv */
// Functional notes
// RULE1 - Only input is three-phase power factor, sampled every 5 ms evaluation cycle.
// RULE2 - Trip pick-up when measured magnitude falls below trip threshold, default 0.80.
// RULE3 - Alarm threshold, default 0.90, evaluated only when alarms are enabled.
// RULE4 - Mode bit selects trips only or trips plus alarms, default both.
// RULE5 - Each pick-up releases only at 103 percent of its own threshold.
// RULE6 - Blocking input is sampled at cycle start, before pick-up processing.
// RULE7 - Pick-up without blocking raises start and runs the operate delay.
// RULE8 - Pick-up with blocking raises blocked and nothing else.
// RULE9 - Blocking after start drops start and runs release timing.
// RULE10 - Blocking source must assert at least 5 ms before delay expires.
// RULE11 - Operate and release timing are definite time only.
// RULE12 - Time-stamped ON/OFF events for five signals, ON/OFF storage selectable.
// RULE13 - Resettable counters for alarm start, alarm, start, trip and blocked.
// RULE14 - Start, trip or blocked ON writes a fault record; newest twelve kept.
// RULE15 - Record holds stamp, event, PF -20 ms, PF now, PF -200 ms, remaining, group.
// RULE16 - Operating mode on, blocked, test, test-blocked or off, default on.
// RULE17 - Forcing, when enabled, sets reported status to a chosen condition.
// RULE18 - Remaining and expected times exposed in 5 ms units.
// RULE19 - Live ratios of measured PF to each threshold in hundredths.
// RULE20 - Thresholds follow active setting group; mode and forcing do not.
// RULE21 - Trip and alarm each have their own definite-time counter.
// RULE22 - Comparison uses magnitude; leading and lagging treated alike.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module power_factor_under_stage import pf_pkg::*; #(
  parameter int unsigned CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement and setting group
  input wire logic signed [7:0] three_phase_power_factor,
  input wire logic [2:0] active_group,
  // Blocking matrix
  input wire logic block_in,
  // Stage outputs
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  output logic alarm_start_out,
  output logic alarm_out,
  // Event stream
  output logic event_valid,
  output logic [3:0] event_code,
  output logic [31:0] event_stamp
);

  localparam logic [DIV_W-1:0] MS_LAST = DIV_W'(CYCLES_PER_MS - 1);
  localparam logic [3:0] REC_LAST = 4'(REC_DEPTH - 1);

  // Registers
  logic [10:0] ctrl_q;
  logic [TIME_W-1:0] trip_delay_q, alarm_delay_q, release_delay_q;
  logic [THR_W-1:0] trip_thr_q [8];
  logic [THR_W-1:0] alarm_thr_q [8];
  logic [3:0] rec_sel_q;

  // Time base and samples
  logic [DIV_W-1:0] ms_cnt_q;
  logic [2:0] sub_q;
  logic [31:0] stamp_q;
  logic ms_tick, eval_tick, proc_tick_q;
  logic block_s_q;
  logic [7:0] pf_mag_q;
  logic [7:0] hist_q [HIST_DEPTH];

  // Protection state
  logic trip_pick_q, alarm_pick_q, trip_pick_d, alarm_pick_d;
  logic start_q, alarm_start_q, blocked_q, blk;
  logic trip_exp, alarm_exp;
  logic [TIME_W-1:0] trip_rem, alarm_rem;
  logic [15:0] ratio_trip_q, ratio_alarm_q;
  logic [THR_W-1:0] act_trip, act_alarm;
  node_operating_mode_t mode;
  logic alarms_en, stage_off, test_mode;

  // Reporting
  logic [NUM_SRC-1:0] state_now, state_prev_q, rise, fall;
  logic [2*NUM_SRC-1:0] pend_q, pend_set, pend_pick;
  logic [CNT_W-1:0] cnt_q [NUM_SRC];
  status_t status;
  logic [NUM_SRC-1:0] shown;

  // Fault records
  logic [2:0] rec_pend_q, rec_pick;
  logic [3:0] wr_ptr_q, rec_count_q, rd_idx;
  logic [4:0] rd_sum;
  logic [31:0] rec_stamp_q [REC_DEPTH];
  logic [27:0] rec_data_q [REC_DEPTH];
  logic [21:0] rec_time_q [REC_DEPTH];

  // APB
  logic setup, access, wr_en, addr_ok, thr_page;
  logic [31:0] rdata;

  assign mode = node_operating_mode_t'(ctrl_q[CTRL_MODE_LSB +: 3]);
  assign alarms_en = ctrl_q[CTRL_ALARMS_BIT];
  assign stage_off = (mode == MODE_OFF);
  assign test_mode = (mode == MODE_TEST) || (mode == MODE_TEST_BLOCKED);
  // Group change swaps thresholds only; mode and forcing live in ctrl_q
  assign act_trip = trip_thr_q[active_group]; // RULE20
  assign act_alarm = alarm_thr_q[active_group]; // RULE20

  // One-millisecond stamp and 5 ms evaluation tick from one divider
  assign ms_tick = (ms_cnt_q == MS_LAST);
  assign eval_tick = ms_tick && (sub_q == MS_PER_EVAL - 3'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_q <= '0;
      sub_q <= '0;
      stamp_q <= '0;
    end else if (ms_tick) begin
      ms_cnt_q <= '0;
      stamp_q <= stamp_q + 32'h0000_0001;
      sub_q <= (sub_q == MS_PER_EVAL - 3'h1) ? 3'h0 : sub_q + 3'h1;
    end else begin
      ms_cnt_q <= ms_cnt_q + 1'b1;
    end
  end

  // Block and sample are taken a cycle before pick-up is evaluated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_s_q <= 1'b0;
      pf_mag_q <= '0;
      proc_tick_q <= 1'b0;
    end else begin
      proc_tick_q <= eval_tick;
      if (eval_tick) begin
        block_s_q <= block_in; // RULE6
        // Lead and lag fold onto one magnitude
        pf_mag_q <= three_phase_power_factor[7] ?
                    8'(-three_phase_power_factor) : 8'(three_phase_power_factor); // RULE1 RULE22
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist_q[i] <= '0;
      end
    end else if (proc_tick_q) begin
      hist_q[0] <= pf_mag_q;
      for (int i = 1; i < HIST_DEPTH; i++) begin
        hist_q[i] <= hist_q[i-1];
      end
    end
  end

  // Pick-up with release at 103 percent of the setting
  always_comb begin
    trip_pick_d = trip_pick_q ?
        (16'(pf_mag_q) * PF_SCALE < 16'(act_trip) * RELEASE_PCT) :
        (pf_mag_q < 8'(act_trip)); // RULE2 RULE5
    alarm_pick_d = alarm_pick_q ?
        (16'(pf_mag_q) * PF_SCALE < 16'(act_alarm) * RELEASE_PCT) :
        (pf_mag_q < 8'(act_alarm)); // RULE3 RULE5
    if (!alarms_en || stage_off) begin
      alarm_pick_d = 1'b0; // RULE3 RULE4
    end
    if (stage_off) begin
      trip_pick_d = 1'b0; // RULE16
    end
  end

  assign blk = block_s_q || (mode == MODE_BLOCKED) || (mode == MODE_TEST_BLOCKED); // RULE16

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_pick_q <= 1'b0;
      alarm_pick_q <= 1'b0;
      start_q <= 1'b0;
      alarm_start_q <= 1'b0;
      blocked_q <= 1'b0;
    end else if (proc_tick_q) begin
      trip_pick_q <= trip_pick_d;
      alarm_pick_q <= alarm_pick_d;
      // Blocking drops start, so the timers see a normal release
      start_q <= trip_pick_d && !blk; // RULE7 RULE9
      alarm_start_q <= alarm_pick_d && !blk; // RULE7 RULE9
      blocked_q <= (trip_pick_d || alarm_pick_d) && blk; // RULE8
    end
  end

  // Run inputs use next start so the start tick is the first counted
  definite_time_timer trip_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tick(proc_tick_q),
    .run(trip_pick_d && !blk),
    .op_delay(trip_delay_q),
    .rel_delay(release_delay_q),
    .expired(trip_exp),
    .remaining(trip_rem)
  ); // RULE11 RULE21

  definite_time_timer alarm_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tick(proc_tick_q),
    .run(alarm_pick_d && !blk),
    .op_delay(alarm_delay_q),
    .rel_delay(release_delay_q),
    .expired(alarm_exp),
    .remaining(alarm_rem)
  ); // RULE11 RULE21

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_trip_q <= '0;
      ratio_alarm_q <= '0;
    end else if (proc_tick_q) begin
      ratio_trip_q <= (16'(pf_mag_q) * PF_SCALE) / 16'(act_trip); // RULE19
      ratio_alarm_q <= (16'(pf_mag_q) * PF_SCALE) / 16'(act_alarm); // RULE19
    end
  end

  // Reported status, with forcing taking over when enabled
  always_comb begin
    state_now = {alarm_exp, alarm_start_q, trip_exp, start_q, blocked_q};
    if (trip_exp) begin
      status = ST_TRIP;
    end else if (start_q) begin
      status = ST_START;
    end else if (alarm_exp) begin
      status = ST_ALARM;
    end else if (alarm_start_q) begin
      status = ST_ALARM_START;
    end else if (blocked_q) begin
      status = ST_BLOCKED;
    end else begin
      status = ST_NORMAL;
    end
    shown = state_now;
    if (ctrl_q[CTRL_FORCE_EN_BIT]) begin
      status = status_t'(ctrl_q[CTRL_FORCE_LSB +: 3]); // RULE17
      shown = '0;
      unique case (status)
        ST_START: shown[SRC_START] = 1'b1;
        ST_TRIP: shown[SRC_TRIP] = 1'b1;
        ST_BLOCKED: shown[SRC_BLOCK] = 1'b1;
        ST_ALARM_START: shown[SRC_ALARM_START] = 1'b1;
        ST_ALARM: shown[SRC_ALARM] = 1'b1;
        default: shown = '0;
      endcase
    end
  end

  // Test modes exercise the logic and the event stream but keep the five stage output pins quiet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {alarm_out, alarm_start_out, trip_out, start_out, blocked_out} <= '0;
    end else begin
      {alarm_out, alarm_start_out, trip_out, start_out, blocked_out} <=
          test_mode ? '0 : shown; // RULE16
    end
  end

  // Events: one pending bit per code, drained one per cycle
  always_comb begin
    rise = shown & ~state_prev_q;
    fall = ~shown & state_prev_q;
    pend_set = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      pend_set[2*s] = rise[s] && ctrl_q[CTRL_STORE_ON_BIT]; // RULE12
      pend_set[2*s+1] = fall[s] && ctrl_q[CTRL_STORE_OFF_BIT]; // RULE12
    end
    pend_pick = pend_q & (~pend_q + 1'b1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_prev_q <= '0;
      pend_q <= '0;
      event_valid <= 1'b0;
      event_code <= '0;
      event_stamp <= '0;
    end else begin
      state_prev_q <= shown;
      // New events win over the one being drained
      pend_q <= (pend_q & ~pend_pick) | pend_set;
      event_valid <= (pend_q != '0);
      event_stamp <= stamp_q; // RULE12
      event_code <= '0;
      for (int k = 0; k < 2*NUM_SRC; k++) begin
        if (pend_pick[k]) begin
          event_code <= 4'(k);
        end
      end
    end
  end

  // Counters: an increment in the clearing cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        cnt_q[s] <= '0;
      end
    end else begin
      for (int s = 0; s < NUM_SRC; s++) begin
        if (rise[s]) begin
          cnt_q[s] <= (wr_en && paddr == OFS_CTRL && pwdata[CTRL_CLEAR_BIT]) ?
                      CNT_W'(1) : cnt_q[s] + 1'b1; // RULE13
        end else if (wr_en && paddr == OFS_CTRL && pwdata[CTRL_CLEAR_BIT]) begin
          cnt_q[s] <= '0; // RULE13
        end
      end
    end
  end

  // Fault records in a ring of twelve, newest overwrites oldest
  assign rec_pick = rec_pend_q & (~rec_pend_q + 1'b1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_pend_q <= '0;
      wr_ptr_q <= '0;
      rec_count_q <= '0;
      for (int r = 0; r < REC_DEPTH; r++) begin
        rec_stamp_q[r] <= '0;
        rec_data_q[r] <= '0;
        rec_time_q[r] <= '0;
      end
    end else begin
      rec_pend_q <= (rec_pend_q & ~rec_pick) |
          {rise[SRC_TRIP], rise[SRC_START], rise[SRC_BLOCK]}; // RULE14
      if (rec_pend_q != '0) begin
        rec_stamp_q[wr_ptr_q] <= stamp_q; // RULE15
        rec_data_q[wr_ptr_q] <= {rec_pick[2] ? 4'(2*SRC_TRIP) :
                                 rec_pick[1] ? 4'(2*SRC_START) : 4'(2*SRC_BLOCK),
                                 hist_q[PRE_TRIGGER_IDX], hist_q[0],
                                 hist_q[PRE_FAULT_IDX]}; // RULE15
        rec_time_q[wr_ptr_q] <= {active_group, trip_rem}; // RULE15
        wr_ptr_q <= (wr_ptr_q == REC_LAST) ? 4'h0 : wr_ptr_q + 4'h1; // RULE14
        if (rec_count_q != 4'(REC_DEPTH)) begin
          rec_count_q <= rec_count_q + 4'h1;
        end
      end
    end
  end

  // Record zero is the newest
  always_comb begin
    rd_sum = 5'(wr_ptr_q) + 5'(REC_DEPTH) - 5'h01 - 5'(rec_sel_q);
    rd_idx = (rd_sum >= 5'(REC_DEPTH)) ? 4'(rd_sum - 5'(REC_DEPTH)) : rd_sum[3:0];
  end

  // APB slave: read data captured in setup, no wait states
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr_en = access && pwrite && addr_ok;
  assign pready = 1'b1;
  assign thr_page = (paddr[7:5] == OFS_THR_PAGE) && (paddr[1:0] == 2'h0);
  assign addr_ok = thr_page || (paddr <= OFS_REC_TIME && paddr[1:0] == 2'h0);
  assign pslverr = access && !addr_ok;

  always_comb begin
    rdata = '0;
    if (thr_page) begin
      rdata = {16'h0, 1'b0, alarm_thr_q[paddr[4:2]], 1'b0, trip_thr_q[paddr[4:2]]};
    end else begin
      unique case (paddr)
        OFS_CTRL: rdata = {21'h0, 1'b0, ctrl_q[9:0]};
        OFS_TRIP_DELAY: rdata = {13'h0, trip_delay_q}; // RULE18
        OFS_ALARM_DELAY: rdata = {13'h0, alarm_delay_q}; // RULE18
        OFS_RELEASE_DELAY: rdata = {13'h0, release_delay_q};
        OFS_STATUS: rdata = {13'h0, active_group, pf_mag_q, shown, status};
        OFS_TRIP_REMAIN: rdata = {13'h0, trip_rem}; // RULE18
        OFS_ALARM_REMAIN: rdata = {13'h0, alarm_rem}; // RULE18
        OFS_RATIO: rdata = {ratio_alarm_q, ratio_trip_q};
        OFS_CNT_A: rdata = {cnt_q[SRC_TRIP], cnt_q[SRC_START]};
        OFS_CNT_B: rdata = {cnt_q[SRC_ALARM_START], cnt_q[SRC_BLOCK]};
        OFS_CNT_C: rdata = {16'h0, cnt_q[SRC_ALARM]};
        OFS_REC_SEL: rdata = {24'h0, rec_count_q, rec_sel_q};
        OFS_REC_STAMP: rdata = (rec_sel_q < rec_count_q) ? rec_stamp_q[rd_idx] : '0;
        OFS_REC_DATA: rdata = (rec_sel_q < rec_count_q) ? {4'h0, rec_data_q[rd_idx]} : '0;
        OFS_REC_TIME: rdata = (rec_sel_q < rec_count_q) ? {10'h0, rec_time_q[rd_idx]} : '0;
        default: rdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup) begin
      prdata <= rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= {1'b0, 1'b1, 1'b1, 1'b0, 3'(ST_NORMAL), 1'b1, 3'(MODE_ON)}; // RULE4 RULE16
      trip_delay_q <= TRIP_DELAY_RST;
      alarm_delay_q <= ALARM_DELAY_RST;
      release_delay_q <= RELEASE_DELAY_RST;
      rec_sel_q <= '0;
      for (int g = 0; g < 8; g++) begin
        trip_thr_q[g] <= TRIP_THR_RST; // RULE2
        alarm_thr_q[g] <= ALARM_THR_RST; // RULE3
      end
    end else if (wr_en) begin
      if (thr_page) begin
        trip_thr_q[paddr[4:2]] <= pwdata[THR_W-1:0];
        alarm_thr_q[paddr[4:2]] <= pwdata[8 +: THR_W];
      end
      unique case (paddr)
        OFS_CTRL: ctrl_q <= {1'b0, pwdata[9:0]};
        OFS_TRIP_DELAY: trip_delay_q <= pwdata[TIME_W-1:0];
        OFS_ALARM_DELAY: alarm_delay_q <= pwdata[TIME_W-1:0];
        OFS_RELEASE_DELAY: release_delay_q <= pwdata[TIME_W-1:0];
        OFS_REC_SEL: rec_sel_q <= pwdata[3:0];
        default: rec_sel_q <= rec_sel_q;
      endcase
    end
  end

endmodule

/* verif/pf_stage_checker.sv */
`timescale 1ns/1ps
module pf_stage_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Stage outputs
  input wire logic start_out,
  input wire logic blocked_out,
  input wire logic event_valid,
  input wire logic [3:0] event_code,
  input wire logic [31:0] event_stamp
);
  logic [31:0] stamp_q;
  logic acc;
  logic bad;
  assign acc = psel && penable;
  // Holes in the map refuse as misaligned words do
  assign bad = (paddr[1:0] != 2'h0) || (paddr == 8'h3C) || (paddr >= 8'h60);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stamp_q <= 32'h0;
    end else if (event_valid) begin
      stamp_q <= event_stamp;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  zero_wait_a: assert property (acc |-> pready)
    else $error("pready low");
  err_idle_a: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access");
  err_bad_a: assert property (acc && bad |-> pslverr)
    else $error("bad address accepted");
  err_good_a: assert property (acc && !bad |-> !pslverr)
    else $error("good address refused");
  err_data_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  start_block_a: assert property (!(start_out && blocked_out))
    else $error("start with blocked");
  event_code_a: assert property (event_valid |-> event_code <= 4'h9)
    else $error("bad event code");
  stamp_order_a: assert property (event_valid |-> event_stamp >= stamp_q)
    else $error("event stamp went back");
endmodule
bind power_factor_under_stage pf_stage_checker i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .start_out(start_out), .blocked_out(blocked_out),
  .event_valid(event_valid), .event_code(event_code), .event_stamp(event_stamp));

/* verif/pf_partner.sv */
`timescale 1ns/1ps
module pf_partner (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Values set by the bench
  input wire logic signed [7:0] pf_set,
  input wire logic block_set,
  // Stage side
  output logic signed [7:0] three_phase_power_factor,
  output logic block_in,
  input wire logic event_valid,
  input wire logic [3:0] event_code,
  // One bit per event code seen
  output logic [9:0] seen
);
  // Refreshed every cycle; the stage takes its own 5 ms samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      three_phase_power_factor <= 8'sh64;
      block_in <= 1'b0;
    end else begin
      three_phase_power_factor <= pf_set;
      block_in <= block_set;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= 10'h000;
    end else if (event_valid && event_code <= 4'h9) begin
      seen[event_code] <= 1'b1;
    end
  end
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
      num_errors++; \
      $display("mismatch %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module testbench import pf_pkg::*; ;
  localparam int TICK = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, blk, ev_v, blk_w;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, ev_s;
  logic signed [7:0] pf, pf_w;
  logic [2:0] grp;
  logic [3:0] ev_c;
  wire [4:0] outs;
  logic [9:0] seen;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n, p;
  integer seed = 32'h7FE0;
  power_factor_under_stage #(.CYCLES_PER_MS(2)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .three_phase_power_factor(pf_w),
    .active_group(grp), .block_in(blk_w), .start_out(outs[0]), .trip_out(outs[1]),
    .blocked_out(outs[2]), .alarm_start_out(outs[3]), .alarm_out(outs[4]),
    .event_valid(ev_v), .event_code(ev_c), .event_stamp(ev_s));
  pf_partner i_far (.pclk(pclk), .presetn(presetn), .pf_set(pf), .block_set(blk),
    .three_phase_power_factor(pf_w), .block_in(blk_w), .event_valid(ev_v),
    .event_code(ev_c), .seen(seen));
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setin(input int v, input logic b);
    @(posedge pclk);
    pf <= 8'(v);
    blk <= b;
  endtask
  // Ends just past an edge so registered outputs have settled
  task automatic ticks(input int k);
    repeat (k * TICK) @(posedge pclk);
    #1;
  endtask
  task automatic wait_out(input int i, output int c);
    c = 0;
    while (outs[i] !== 1'b1 && c < 400) begin
      @(posedge pclk);
      #1;
      c++;
    end
  endtask
  function automatic logic [15:0] ratio(input int v, input int th);
    return 16'((v < 0 ? -v : v) * 100 / th);
  endfunction
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pf = 8'sh64;
    blk = 1'b0;
    grp = 3'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h308, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("thr", 32'h5A50, rd)
    apb(1'b0, 8'h3C, 32'h0);
    `CHK("hole", 1'b1, err)
    apb(1'b1, OFS_CTRL, 32'h708);
    apb(1'b1, OFS_TRIP_DELAY, 32'h4);
    apb(1'b1, 8'h44, 32'h5A3C);
    $display("done defaults");
    setin(-70, 1'b0);
    wait_out(0, n);
    `CHK("start", 1'b1, outs[0])
    wait_out(1, n);
    `CHK("trip_dly", 3 * TICK, n)
    apb(1'b0, OFS_CNT_A, 32'h0);
    `CHK("cnt", 32'h0001_0001, rd)
    `CHK("ev_on", 2'b11, {seen[4], seen[2]})
    setin(82, 1'b0);
    ticks(3);
    `CHK("hold", 1'b1, outs[0])
    setin(83, 1'b0);
    ticks(3);
    `CHK("release", 1'b0, outs[0])
    `CHK("ev_off", 2'b11, {seen[5], seen[3]})
    $display("done trip");
    setin(70, 1'b0);
    wait_out(0, n);
    setin(70, 1'b1);
    ticks(3);
    `CHK("blk_late", 2'b10, {outs[2], outs[0]})
    setin(100, 1'b1);
    ticks(3);
    setin(70, 1'b1);
    ticks(3);
    `CHK("blk_pick", 2'b10, {outs[2], outs[0]})
    setin(85, 1'b0);
    ticks(3);
    `CHK("al_start", 2'b10, {outs[3], outs[0]})
    apb(1'b1, OFS_CTRL, 32'h300);
    ticks(3);
    `CHK("al_off", 1'b0, outs[3])
    $display("done blocking");
    setin(70, 1'b0);
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, OFS_CTRL, 32'h300 | 32'(m));
      ticks(2);
      `CHK("mode", (m == 0) ? 2'b01 : (m == 1) ? 2'b10 : 2'b00, {outs[2], outs[0]})
    end
    setin(100, 1'b0);
    for (int s = 1; s < 6; s++) begin
      apb(1'b1, OFS_CTRL, 32'h388 | 32'(s << 4));
      ticks(2);
      `CHK("force", 1'b1, outs[s - 1])
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK("status", 3'(s), rd[2:0])
    end
    apb(1'b1, OFS_CTRL, 32'h308);
    $display("done modes");
    for (int k = 0; k < 6; k++) begin
      p = 60 + ($random(seed) & 32'h1F);
      if ($random(seed) & 1) p = -p;
      setin(p, 1'b0);
      grp <= {2'b00, 1'($random(seed))};
      ticks(2);
      apb(1'b0, OFS_RATIO, 32'h0);
      `CHK("ratio_t", ratio(p, grp[0] ? 60 : 80), rd[15:0])
      `CHK("ratio_a", ratio(p, 90), rd[31:16])
    end
    $display("done ratios");
    setin(100, 1'b0);
    grp <= 3'h0;
    for (int i = 0; i < 13; i++) begin
      setin(70, 1'b0);
      ticks(2);
      setin(100, 1'b0);
      ticks(2);
    end
    apb(1'b0, OFS_REC_SEL, 32'h0);
    `CHK("rec_cnt", 4'hC, rd[7:4])
    apb(1'b0, OFS_REC_DATA, 32'h0);
    `CHK("rec_data", 12'h246, {rd[27:24], rd[15:8]})
    $display("done records");
    test_done();
  end
endmodule
